// ==== design/smc_config_word.sv ====
// Modulator configuration word, serial load and auto power-up
`timescale 1ns/10ps
// Functional notes
// - Fixed bit positions for all fields
// - Auto power-up powers loops on divider write
// - Auto power-up clears both power-down bits
// - Chip enable low suppresses auto power-up
// - Dither 0 off, 1 weak, 2 strong
// - Order codes 0,2,3 give 4th,2nd,3rd
// - Order code 1 disables the modulator
module smc_config_word
(
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 ser_clk,
   input  wire logic                 ser_data,
   input  wire logic                 ser_latch,
   input  wire logic                 chip_enable,
   input  wire logic                 pd_write,
   input  wire logic                 main_pd_value,
   input  wire logic                 aux_pd_value,
   output smc_pkg::smc_cfg_t         cfg,
   output smc_pkg::smc_mod_t         mod,
   output logic                      main_loop_power_down,
   output logic                      aux_loop_power_down,
   output logic                      main_divider_written
);
   // ************************************************************
   // Serial shift register
   // ************************************************************
   // Pins taken as synchronous; edges found by one stage of history
   logic [smc_pkg::WORD_W-1:0] shift_reg, shift_next;
   logic                       sck_reg, sck_next;
   logic                       le_reg, le_next;
   logic                       sck_rise, le_rise;

   always_comb
   begin
      sck_rise   = ser_clk & ~sck_reg;
      le_rise    = ser_latch & ~le_reg;
      sck_next   = ser_clk;
      le_next    = ser_latch;
      shift_next = shift_reg;
      if (sck_rise)
      begin
         shift_next = {shift_reg[smc_pkg::WORD_W-2:0], ser_data};
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         shift_reg <= '0;
         sck_reg   <= 1'b0;
         le_reg    <= 1'b0;
      end
      else
      begin
         shift_reg <= shift_next;
         sck_reg   <= sck_next;
         le_reg    <= le_next;
      end
   end

   // ************************************************************
   // Word decoding helpers
   // ************************************************************
   // Word code sits in the low nibble of every serial word
   function automatic logic code_matches
   (
      input logic [smc_pkg::WORD_W-1:0] word,
      input logic [3:0]                 code
   );
      return (word[3:0] == code);
   endfunction : code_matches

   // Shared by the load path and the reset value
   function automatic smc_pkg::smc_cfg_t word_to_cfg
   (
      input logic [smc_pkg::WORD_W-1:0] word
   );
      smc_pkg::smc_cfg_t f;
      f                         = '0;
      // Fixed bits are not checked; the host keeps them
      f.auto_power_up           = word[smc_pkg::POS_AUTO_PU];
      f.dither_level            = word[smc_pkg::POS_DITHER_HI:smc_pkg::POS_DITHER_LO];
      f.modulator_order         = word[smc_pkg::POS_ORDER_HI:smc_pkg::POS_ORDER_LO];
      f.ref_doubler_enable      = word[smc_pkg::POS_DOUBLER];
      f.ref_buffer_out_enable   = word[smc_pkg::POS_BUF_OUT];
      f.aux_pump_polarity       = word[smc_pkg::POS_AUX_POL];
      f.main_pump_polarity      = word[smc_pkg::POS_MAIN_POL];
      f.aux_prescaler_sel       = word[smc_pkg::POS_AUX_PRESC];
      f.test_lock_output_select = word[smc_pkg::POS_SEL_HI:smc_pkg::POS_SEL_LO];
      return f;
   endfunction : word_to_cfg

   // ************************************************************
   // Latch strobe decoding
   // ************************************************************
   logic is_cfg, is_div;

   always_comb
   begin
      is_cfg = le_rise && code_matches(shift_reg, smc_pkg::CODE_MOD_CFG);
      is_div = le_rise && code_matches(shift_reg, smc_pkg::CODE_MAIN_DIV);
   end

   // ************************************************************
   // Configuration fields
   // ************************************************************
   // No usable default; reset only keeps outputs defined
   smc_pkg::smc_cfg_t cfg_reg, cfg_next;

   always_comb
   begin
      cfg_next = cfg_reg;
      if (is_cfg)
      begin
         cfg_next = word_to_cfg(shift_reg);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cfg_reg <= word_to_cfg(smc_pkg::CFG_RESET);
      end
      else
      begin
         cfg_reg <= cfg_next;
      end
   end

   // ************************************************************
   // Modulator controls
   // ************************************************************
   // Decoded from next fields so controls move with the word
   smc_pkg::smc_mod_t mod_reg, mod_next;

   smc_decode u_decode
   (
      .dither_level    (cfg_next.dither_level),
      .modulator_order (cfg_next.modulator_order),
      .mod             (mod_next)
   );

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mod_reg <= smc_pkg::smc_mod_t'(smc_pkg::MOD_RESET);
      end
      else
      begin
         mod_reg <= mod_next;
      end
   end

   // ************************************************************
   // Loop power-down bits
   // ************************************************************
   // Bit 1 main loop, bit 0 auxiliary loop; high is powered down
   logic [1:0] pd_reg, pd_next;
   logic       auto_pu_fire;

   always_comb
   begin
      // Stored enable used; one word never loads both codes
      auto_pu_fire = is_div && cfg_reg.auto_power_up && chip_enable;
      pd_next      = pd_reg;
      // Explicit loop control writes first; auto power-up overrides
      if (pd_write)
      begin
         pd_next = {main_pd_value, aux_pd_value};
      end
      if (auto_pu_fire)
      begin
         pd_next = 2'h0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pd_reg <= smc_pkg::PD_RESET;
      end
      else
      begin
         pd_reg <= pd_next;
      end
   end

   // ************************************************************
   // Main divider write pulse
   // ************************************************************
   // One clock wide
   logic div_wr_reg, div_wr_next;

   always_comb
   begin
      div_wr_next = is_div;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         div_wr_reg <= 1'b0;
      end
      else
      begin
         div_wr_reg <= div_wr_next;
      end
   end

   // ************************************************************
   // Outputs, each straight from a flip-flop
   // ************************************************************
   assign cfg                  = cfg_reg;
   assign mod                  = mod_reg;
   assign main_loop_power_down = pd_reg[1];
   assign aux_loop_power_down  = pd_reg[0];
   assign main_divider_written = div_wr_reg;
endmodule : smc_config_word

// ==== design/smc_pkg.sv ====
// Package for the modulator configuration word block
package smc_pkg;
   // ************************************************************
   // Word layout
   // ************************************************************
   localparam int WORD_W          = 24;
   localparam int POS_AUTO_PU     = 23;
   localparam int POS_DITHER_HI   = 17;
   localparam int POS_DITHER_LO   = 16;
   localparam int POS_ORDER_HI    = 15;
   localparam int POS_ORDER_LO    = 14;
   localparam int POS_DOUBLER     = 12;
   localparam int POS_BUF_OUT     = 11;
   localparam int POS_AUX_POL     = 10;
   localparam int POS_MAIN_POL    = 9;
   localparam int POS_AUX_PRESC   = 8;
   localparam int POS_SEL_HI      = 7;
   localparam int POS_SEL_LO      = 4;
   localparam logic [3:0] CODE_MOD_CFG  = 4'h9;
   localparam logic [3:0] CODE_MAIN_DIV = 4'h0;
   // Reset state: nothing usable; host must program the word
   localparam logic [WORD_W-1:0] CFG_RESET = 24'h000000;
   localparam logic [1:0] PD_RESET = 2'h3;
   // Modulator off only in reset; first clock after decodes CFG_RESET as enabled 4th order
   localparam logic [5:0] MOD_RESET = 6'h00;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0]
   {
      SMC_DITHER_OFF    = 2'b00,
      SMC_DITHER_WEAK   = 2'b01,
      SMC_DITHER_STRONG = 2'b10,
      SMC_DITHER_RSVD   = 2'b11
   } smc_dither_t;

   typedef enum logic [2:0]
   {
      SMC_ORD_OFF = 3'b000,
      SMC_ORD_2   = 3'b010,
      SMC_ORD_3   = 3'b011,
      SMC_ORD_4   = 3'b100
   } smc_order_t;

   typedef struct packed
   {
      logic       auto_power_up;
      logic [1:0] dither_level;
      logic [1:0] modulator_order;
      logic       ref_doubler_enable;
      logic       ref_buffer_out_enable;
      logic       aux_pump_polarity;
      logic       main_pump_polarity;
      logic       aux_prescaler_sel;
      logic [3:0] test_lock_output_select;
   } smc_cfg_t;

   typedef struct packed
   {
      logic       modulator_enable;
      logic [2:0] modulator_order;
      logic       dither_enable;
      logic       dither_strong;
   } smc_mod_t;
endpackage : smc_pkg

// ==== design/smc_decode.sv ====
// Decoder from configuration fields to modulator controls
`timescale 1ns/10ps
module smc_decode
(
   input  wire logic [1:0]     dither_level,
   input  wire logic [1:0]     modulator_order,
   output smc_pkg::smc_mod_t   mod
);
   always_comb
   begin
      mod = '0;
      case (modulator_order)
         2'h0: mod.modulator_order = smc_pkg::SMC_ORD_4;
         2'h1: mod.modulator_order = smc_pkg::SMC_ORD_OFF;
         2'h2: mod.modulator_order = smc_pkg::SMC_ORD_2;
         default: mod.modulator_order = smc_pkg::SMC_ORD_3;
      endcase
      mod.modulator_enable = (modulator_order != 2'h1);
      // Reserved dither code treated as off, the safe choice
      case (dither_level)
         2'h1:
         begin
            mod.dither_enable = 1'b1;
         end
         2'h2:
         begin
            mod.dither_enable = 1'b1;
            mod.dither_strong = 1'b1;
         end
         default:
         begin
            mod.dither_enable = 1'b0;
         end
      endcase
   end
endmodule : smc_decode

// ==== tb/smc_monitor.sv ====
// Checker for the modulator configuration word block
`timescale 1ns/10ps
module smc_monitor
(
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              ser_clk,
   input wire logic              ser_data,
   input wire logic              ser_latch,
   input wire logic              chip_enable,
   input wire logic              pd_write,
   input wire smc_pkg::smc_cfg_t cfg,
   input wire smc_pkg::smc_mod_t mod,
   input wire logic              main_loop_power_down,
   input wire logic              aux_loop_power_down,
   input wire logic              main_divider_written
);
   // ****
   // Shadow shift register, same sampling as the port
   // ****
   logic [23:0] sh_reg;
   logic        ck_reg;
   always_ff @(posedge clk)
   begin
      ck_reg <= ser_clk;
      if (ser_clk && !ck_reg)
         sh_reg <= {sh_reg[22:0], ser_data};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_word_load: assert property ($rose(ser_latch) && sh_reg[3:0] == 4'h9
      |=> cfg == {sh_reg[23], sh_reg[17:14], sh_reg[12:4]}) else $error("cfg load wrong");
   a_code_other: assert property ($rose(ser_latch) && sh_reg[3:0] != 4'h9
      |=> $stable(cfg)) else $error("cfg changed by other code");
   a_latch_only: assert property (!$rose(ser_latch) |=> $stable(cfg))
      else $error("cfg changed without latch");
   a_order_off: assert property ($changed(cfg) && cfg.modulator_order == 2'h1
      |-> !mod.modulator_enable) else $error("modulator not off");
   a_order_map: assert property ($changed(cfg) && cfg.modulator_order != 2'h1
      |-> mod.modulator_enable && mod.modulator_order == ((cfg.modulator_order == 2'h0)
      ? 3'h4 : {1'b0, cfg.modulator_order})) else $error("order decode wrong");
   a_dither_map: assert property ($changed(cfg) |-> mod.dither_strong ==
      (cfg.dither_level == 2'h2) && mod.dither_enable == (cfg.dither_level inside {2'h1, 2'h2}))
      else $error("dither decode wrong");
   a_auto_pu: assert property (main_divider_written && $past(cfg.auto_power_up)
      && $past(chip_enable) |-> !main_loop_power_down && !aux_loop_power_down)
      else $error("no auto power up");
   a_pu_blocked: assert property (main_divider_written && !$past(pd_write)
      && !($past(cfg.auto_power_up) && $past(chip_enable)) |-> $stable(main_loop_power_down)
      && $stable(aux_loop_power_down)) else $error("power down bits moved");
endmodule : smc_monitor
bind smc_config_word smc_monitor MON
(
   .clk                  (clk),
   .reset                (reset),
   .ser_clk              (ser_clk),
   .ser_data             (ser_data),
   .ser_latch            (ser_latch),
   .chip_enable          (chip_enable),
   .pd_write             (pd_write),
   .cfg                  (cfg),
   .mod                  (mod),
   .main_loop_power_down (main_loop_power_down),
   .aux_loop_power_down  (aux_loop_power_down),
   .main_divider_written (main_divider_written)
);

// ==== tb/smc_host.sv ====
// Host controller model driving the three-wire programming port
`timescale 1ns/10ps
module smc_host
(
   input  wire logic clk,
   output logic      ser_clk,
   output logic      ser_data,
   output logic      ser_latch
);
   initial
   begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch = 1'b0;
   end
   // Bit 23 first; hold slows each half period
   task automatic send(input logic [23:0] w, input int hold);
      for (int i = 23; i >= 0; i--)
      begin
         @(negedge clk);
         ser_clk = 1'b0;
         ser_data = w[i];
         repeat (hold) @(negedge clk);
         @(negedge clk);
         ser_clk = 1'b1;
         repeat (hold) @(negedge clk);
      end
      @(negedge clk);
      ser_clk = 1'b0;
      ser_data = ~ser_data;  // Last bit inverted on the data line, no stale bit
      ser_latch = 1'b1;
      @(negedge clk);
      ser_latch = 1'b0;
   endtask : send
endmodule : smc_host

// ==== tb/tb_top.sv ====
// Testbench for the modulator configuration word block
`timescale 1ns/10ps
module tb_top;
   logic              clk, reset, chip_enable, pd_write, main_pd_in, aux_pd_in;
   logic              ser_clk, ser_data, ser_latch, main_dw;
   logic              main_pd, aux_pd;
   smc_pkg::smc_cfg_t cfg;
   smc_pkg::smc_mod_t mod;
   logic [23:0]       w;
   int                compares = 0;
   int                miscompares = 0;
   smc_host HOST (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
   smc_config_word DUT (.clk(clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
      .ser_latch(ser_latch), .chip_enable(chip_enable), .pd_write(pd_write),
      .main_pd_value(main_pd_in), .aux_pd_value(aux_pd_in), .cfg(cfg), .mod(mod),
      .main_loop_power_down(main_pd), .aux_loop_power_down(aux_pd),
      .main_divider_written(main_dw));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   function automatic logic [23:0] mk(input logic a, input logic [1:0] d, input logic [1:0] o);
      return {a, 5'h08, d, o, 1'b0, 9'h1a5, 4'h9};
   endfunction : mk
   initial
   begin
      reset = 1'b1;
      chip_enable = 1'b1;
      pd_write = 1'b0;
      main_pd_in = 1'b0;
      aux_pd_in = 1'b0;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      chk("mod", 16'(mod), 16'(smc_pkg::MOD_RESET));
      chk("pd", {14'h0, main_pd, aux_pd}, 16'(smc_pkg::PD_RESET));
      chk("pulse", 16'(main_dw), 16'h0);
      // ****
      // Dither codes 0 to 2 and every order code, host speed varied
      // ****
      for (int d = 0; d < 3; d++)
         for (int o = 0; o < 4; o++)
         begin
            w = mk(1'b0, d[1:0], o[1:0]);
            HOST.send(w, o);
            chk("cfg", 16'(cfg), {2'h0, w[23], w[17:14], w[12:4]});
            chk("mod", 16'(mod), {10'h0, o != 1, (o == 0) ? 3'h4 : (o == 1) ? 3'h0 : 3'(o),
               d == 1 || d == 2, d == 2});
         end
      HOST.send({~w[23:4], 4'h8}, 0);
      chk("kept", 16'(cfg), {2'h0, w[23], w[17:14], w[12:4]});
      chk("pulse", 16'(main_dw), 16'h0);
      // Mid-run reset, held two cycles
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      chk("cfg", 16'(cfg), 16'h0);
      chk("mod", 16'(mod), 16'(smc_pkg::MOD_RESET));
      chk("pd", {14'h0, main_pd, aux_pd}, 16'(smc_pkg::PD_RESET));
      // ****
      // Auto power-up: enabled, chip disabled, bit off
      // ****
      for (int k = 0; k < 3; k++)
      begin
         HOST.send(mk(k != 2, 2'h1, 2'h2), 0);
         chip_enable = (k != 1);
         @(negedge clk);
         pd_write = 1'b1;
         main_pd_in = 1'b1;
         aux_pd_in = 1'b1;
         @(negedge clk);
         pd_write = 1'b0;
         HOST.send(24'h123450, 1);
         chk("pulse", 16'(main_dw), 16'h1);
         chk("pd", {14'h0, main_pd, aux_pd}, (k == 0) ? 16'h0 : 16'h3);
      end
      finish_test();
   end
endmodule : tb_top
